// ---- strap_led_cfg.svh ----
// Constants for the strap and indicator block: register offsets, bit positions, timing.
// Assumes a 40 MHz core clock and a 5-bit register address port.
`ifndef STRAP_LED_CFG_SVH
`define STRAP_LED_CFG_SVH

`define SL_ADDR_W 5
`define SL_DATA_W 16
`define SL_REG_CONTROL 5'h00
`define SL_REG_STRAPSTAT 5'h10
`define SL_REG_LEDCFG 5'h13
`define SL_REG_LEDALT 5'h1A
`define SL_BIT_ANEN_CTL 12
`define SL_BIT_SPEED_LOW 12
`define SL_BIT_SPEED_HIGH 13
`define SL_BIT_DUPLEX 14
`define SL_BIT_ANEN 15
`define SL_BIT_THREE_IN_ONE 5
`define SL_BIT_FOUR_IN_ONE 0
`define SL_CLK_MHZ 40
`define SL_SIGDET_US 500
`define SL_SIGDET_CYCLES (`SL_SIGDET_US * `SL_CLK_MHZ)
`define SL_BLINK_US 50000
`define SL_BLINK_CYCLES (`SL_BLINK_US * `SL_CLK_MHZ)
`define SL_ZERO16 16'h0000

`endif

// ---- strap_led_pkg.sv ----
// Types shared by the strap and indicator block.
// Assumes strap_led_cfg.svh supplies the numeric constants.
`default_nettype none
package strap_led_pkg;
  typedef struct packed {
    logic autonegEnableStrap;
    logic duplexStrap;
    logic speedSelectHighStrap;
    logic speedSelectLowStrap;
  } strap_s;

  typedef struct packed {
    logic link10;
    logic trainingDone;
    logic autonegDone;
    logic gigLinkValid;
    logic remoteRxOk;
    logic idleError;
    logic txActive;
    logic rxActive;
  } core_status_s;

  typedef struct packed {
    logic adv1000;
    logic adv100;
    logic adv10;
  } advert_s;

  typedef enum logic {PH_SAMPLE, PH_RUN} phase_e;
endpackage : strap_led_pkg
`default_nettype wire

// ---- strap_and_led_status.sv ----
// Dual-function strap/indicator pins of a 10/100/1000 transceiver, plus their registers.
// Assumes core status inputs are synchronous to mclk; indicator outputs are active high (lit).
//
// The placing of the registers and the address-and-strobe port were chosen for this implementation.
`include "strap_led_cfg.svh"
`default_nettype none

module strap_and_led_status #(
  parameter logic [31:0] SIGDET_CYCLES = `SL_SIGDET_CYCLES,
  parameter logic [31:0] BLINK_CYCLES = `SL_BLINK_CYCLES
) (
  input wire logic mclk, // Core clock, 40 MHz
  input wire logic arst_n, // Asynchronous reset, active low
  input wire logic [`SL_ADDR_W-1:0] regAddr, // Register address
  input wire logic [`SL_DATA_W-1:0] regWdata, // Register write data
  input wire logic regWr, // Write strobe
  input wire logic regRd, // Read strobe
  output logic [`SL_DATA_W-1:0] regRdata, // Read data, cycle after regRd
  input wire strap_led_pkg::core_status_s coreStatus, // Link and traffic state from the core
  input wire logic rxAmplitudeOk, // Receive amplitude within medium limits
  input wire logic activityPinIn, // Pin level: speed_select_low_strap
  output logic activityPinOut, // Activity indicator drive
  output logic activityPinOe_n, // Low while driving
  input wire logic link10PinIn, // Pin level: speed_select_high_strap
  output logic link10PinOut, // 10M or reduced_mode_indicator drive
  output logic link10PinOe_n, // Low while driving
  input wire logic link100PinIn, // Pin level: duplex strap
  output logic link100PinOut, // link_100m_indicator drive
  output logic link100PinOe_n, // Low while driving
  input wire logic link1000PinIn, // Pin level: autoneg_enable_strap
  output logic link1000PinOut, // link_1000m_indicator drive
  output logic link1000PinOe_n, // Low while driving
  output strap_led_pkg::advert_s advertise, // Advertised speed abilities
  output logic autonegEnable, // Auto-negotiation enable control
  output logic fullDuplexAllowed // Default duplex: full allowed
);

  strap_led_pkg::phase_e phase;
  strap_led_pkg::phase_e next_phase;
  strap_led_pkg::strap_s strap;
  strap_led_pkg::strap_s next_strap;
  logic anCtl;
  logic next_anCtl;
  logic threeInOne;
  logic next_threeInOne;
  logic fourInOne;
  logic next_fourInOne;
  logic [`SL_DATA_W-1:0] next_regRdata;

  logic [31:0] sdCount;
  logic [31:0] next_sdCount;
  logic [31:0] blinkCount;
  logic [31:0] next_blinkCount;
  logic blinkPhase;
  logic next_blinkPhase;

  logic next_activityPinOut;
  logic next_link10PinOut;
  logic next_link100PinOut;
  logic next_link1000PinOut;
  logic next_oe_n;
  strap_led_pkg::advert_s next_advertise;
  logic next_fullDuplexAllowed;

  logic signalDetect;
  logic link100Good;
  logic link1000Good;
  logic trafficSeen;
  logic anyLink;
  logic mergedLed;
  logic reducedMode;

  // Strap capture and register file
  always_comb
  begin
    next_phase = strap_led_pkg::PH_RUN;
    next_strap = strap;
    next_anCtl = anCtl;
    next_threeInOne = threeInOne;
    next_fourInOne = fourInOne;
    next_regRdata = `SL_ZERO16;
    if (phase == strap_led_pkg::PH_SAMPLE)
    begin
      // Pins are still undriven here, so they show only the pull resistors
      next_strap.speedSelectLowStrap = activityPinIn;
      next_strap.speedSelectHighStrap = link10PinIn;
      next_strap.duplexStrap = link100PinIn;
      next_strap.autonegEnableStrap = link1000PinIn;
      next_anCtl = link1000PinIn;
    end
    else if (regWr)
    begin
      case (regAddr)
        `SL_REG_CONTROL: next_anCtl = regWdata[`SL_BIT_ANEN_CTL];
        `SL_REG_LEDCFG: next_threeInOne = regWdata[`SL_BIT_THREE_IN_ONE];
        `SL_REG_LEDALT: next_fourInOne = regWdata[`SL_BIT_FOUR_IN_ONE];
        default: next_anCtl = anCtl;
      endcase
    end
    if (regRd)
    begin
      case (regAddr)
        `SL_REG_CONTROL: next_regRdata[`SL_BIT_ANEN_CTL] = anCtl;
        `SL_REG_STRAPSTAT:
        begin
          next_regRdata[`SL_BIT_SPEED_LOW] = strap.speedSelectLowStrap;
          next_regRdata[`SL_BIT_SPEED_HIGH] = strap.speedSelectHighStrap;
          next_regRdata[`SL_BIT_DUPLEX] = strap.duplexStrap;
          next_regRdata[`SL_BIT_ANEN] = strap.autonegEnableStrap;
        end
        `SL_REG_LEDCFG: next_regRdata[`SL_BIT_THREE_IN_ONE] = threeInOne;
        `SL_REG_LEDALT: next_regRdata[`SL_BIT_FOUR_IN_ONE] = fourInOne;
        default: next_regRdata = `SL_ZERO16;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      phase <= strap_led_pkg::PH_SAMPLE;
      strap <= '0;
      anCtl <= 1'b0;
      threeInOne <= 1'b0;
      fourInOne <= 1'b0;
      regRdata <= `SL_ZERO16;
    end
    else
    begin
      phase <= next_phase;
      strap <= next_strap;
      anCtl <= next_anCtl;
      threeInOne <= next_threeInOne;
      fourInOne <= next_fourInOne;
      regRdata <= next_regRdata;
    end
  end

  // Link qualification and indicator drive
  always_comb
  begin
    signalDetect = rxAmplitudeOk;
    // Counter saturates so a long-held link never wraps back to dark
    if (!signalDetect)
      next_sdCount = '0;
    else if (sdCount < SIGDET_CYCLES)
      next_sdCount = sdCount + 32'h0000_0001;
    else
      next_sdCount = sdCount;
    link100Good = signalDetect && (sdCount >= SIGDET_CYCLES - 32'h0000_0001);
    link1000Good = coreStatus.trainingDone && coreStatus.autonegDone
      && coreStatus.gigLinkValid && coreStatus.remoteRxOk;
    trafficSeen = coreStatus.idleError || coreStatus.txActive || coreStatus.rxActive;
    anyLink = coreStatus.link10 || link100Good || link1000Good;

    if (blinkCount >= BLINK_CYCLES - 32'h0000_0001)
    begin
      next_blinkCount = '0;
      next_blinkPhase = !blinkPhase;
    end
    else
    begin
      next_blinkCount = blinkCount + 32'h0000_0001;
      next_blinkPhase = blinkPhase;
    end
    // Four-in-one wins when both reduced modes are set
    reducedMode = threeInOne || fourInOne;
    mergedLed = trafficSeen ? blinkPhase : anyLink;

    next_oe_n = (phase == strap_led_pkg::PH_SAMPLE);
    next_activityPinOut = fourInOne ? 1'b0 : trafficSeen;
    next_link10PinOut = reducedMode ? mergedLed : coreStatus.link10;
    next_link100PinOut = reducedMode ? 1'b0 : link100Good;
    next_link1000PinOut = reducedMode ? 1'b0 : link1000Good;

    next_advertise.adv1000 = 1'b1;
    next_advertise.adv100 = !strap.speedSelectHighStrap && !strap.speedSelectLowStrap
      || !strap.speedSelectHighStrap && strap.speedSelectLowStrap;
    next_advertise.adv10 = !strap.speedSelectHighStrap && !strap.speedSelectLowStrap
      || strap.speedSelectHighStrap && strap.speedSelectLowStrap;
    next_fullDuplexAllowed = strap.duplexStrap;
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sdCount <= '0;
      blinkCount <= '0;
      blinkPhase <= 1'b0;
      advertise <= '0;
      autonegEnable <= 1'b0;
      fullDuplexAllowed <= 1'b0;
    end
    else
    begin
      sdCount <= next_sdCount;
      blinkCount <= next_blinkCount;
      blinkPhase <= next_blinkPhase;
      advertise <= next_advertise;
      autonegEnable <= next_anCtl;
      fullDuplexAllowed <= next_fullDuplexAllowed;
    end
  end

  indicator_pin_reg #(
    .RESET_LEVEL(1'b0)
  ) i_activityPin (
    .mclk(mclk),
    .arst_n(arst_n),
    .next_lit(next_activityPinOut),
    .next_oe_n(next_oe_n),
    .pinOut(activityPinOut),
    .pinOe_n(activityPinOe_n)
  );

  indicator_pin_reg #(
    .RESET_LEVEL(1'b0)
  ) i_link10Pin (
    .mclk(mclk),
    .arst_n(arst_n),
    .next_lit(next_link10PinOut),
    .next_oe_n(next_oe_n),
    .pinOut(link10PinOut),
    .pinOe_n(link10PinOe_n)
  );

  indicator_pin_reg #(
    .RESET_LEVEL(1'b0)
  ) i_link100Pin (
    .mclk(mclk),
    .arst_n(arst_n),
    .next_lit(next_link100PinOut),
    .next_oe_n(next_oe_n),
    .pinOut(link100PinOut),
    .pinOe_n(link100PinOe_n)
  );

  indicator_pin_reg #(
    .RESET_LEVEL(1'b0)
  ) i_link1000Pin (
    .mclk(mclk),
    .arst_n(arst_n),
    .next_lit(next_link1000PinOut),
    .next_oe_n(next_oe_n),
    .pinOut(link1000PinOut),
    .pinOe_n(link1000PinOe_n)
  );

endmodule : strap_and_led_status

// One shared pin: registered indicator level and its output enable
module indicator_pin_reg #(
  parameter logic RESET_LEVEL = 1'b0
) (
  input wire logic mclk, // Core clock
  input wire logic arst_n, // Asynchronous reset, active low
  input wire logic next_lit, // Indicator level for the next cycle
  input wire logic next_oe_n, // Output enable for the next cycle, low to drive
  output logic pinOut, // Registered indicator drive
  output logic pinOe_n // Registered output enable, low while driving
);

  // Released in reset so that only the strap resistor sets the pin level
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pinOut <= RESET_LEVEL;
      pinOe_n <= 1'b1;
    end
    else
    begin
      pinOut <= next_lit;
      pinOe_n <= next_oe_n;
    end
  end

endmodule : indicator_pin_reg
`default_nettype wire

// ---- strap_pin_model.sv ----
// Pull resistors and indicator loads on the four shared pins.
// Assumes the bench sets each pull level before reset release.
`default_nettype none
module strap_pin_model (
  input wire logic [3:0] pull, // Resistor level per pin
  input wire logic [3:0] drive, // Device drive per pin
  input wire logic [3:0] driveOe_n, // Low while device drives
  output logic [3:0] level // Wire level seen by the device
);
  timeunit 1ns;
  timeprecision 1ps;
  // A released pin falls to its resistor, never keeps the last driven level
  assign level = (drive & ~driveOe_n) | (pull & driveOe_n);
endmodule : strap_pin_model
`default_nettype wire

// ---- strap_and_led_status_assertions.sv ----
// Checker on the ports of the strap and indicator block.
// Assumes bind into strap_and_led_status with its signal-detect count.
`include "strap_led_cfg.svh"
`default_nettype none
module strap_and_led_status_assertions #(
  parameter logic [31:0] SIGDET_CYCLES = `SL_SIGDET_CYCLES
) (
  input wire logic mclk, // Clock
  input wire logic arst_n, // Reset
  input wire logic [`SL_ADDR_W-1:0] regAddr, // Address
  input wire logic regRd, // Read strobe
  input wire logic [`SL_DATA_W-1:0] regRdata, // Read data
  input wire strap_led_pkg::core_status_s coreStatus, // Core state
  input wire logic rxAmplitudeOk, // Signal detect
  input wire logic activityPinIn, // Pin level
  input wire logic link10PinIn, // Pin level
  input wire logic link100PinIn, // Pin level
  input wire logic link1000PinIn, // Pin level
  input wire logic activityPinOut, // Indicator
  input wire logic link100PinOut, // Indicator
  input wire logic link1000PinOut, // Indicator
  input wire logic activityPinOe_n, // Enable
  input wire strap_led_pkg::advert_s advertise, // Abilities
  input wire logic autonegEnable, // AN control
  input wire logic fullDuplexAllowed // Duplex default
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] strap;
  logic [15:0] ampRun;
  // Own copy of the straps, taken while the pins are still released
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      strap <= 4'h0;
      ampRun <= 16'h0000;
    end
    else
    begin
      if (activityPinOe_n)
        strap <= {link1000PinIn, link100PinIn, link10PinIn, activityPinIn};
      if (!rxAmplitudeOk)
        ampRun <= 16'h0000;
      else if (ampRun != 16'hffff)
        ampRun <= ampRun + 16'h0001;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  property p_act; activityPinOut |-> $past(coreStatus.idleError | coreStatus.txActive | coreStatus.rxActive); endproperty
  a_act: assert property (p_act) else $error("activity lit without traffic");
  property p_gig; link1000PinOut |-> $past(coreStatus[6:3] == 4'hf); endproperty
  a_gig: assert property (p_gig) else $error("gigabit lit without full qualification");
  property p_wait; $rose(link100PinOut) |-> {16'h0000, ampRun} >= SIGDET_CYCLES; endproperty
  a_wait: assert property (p_wait) else $error("100M lit too early");
  property p_drop; !rxAmplitudeOk |=> !link100PinOut; endproperty
  a_drop: assert property (p_drop) else $error("100M not dark after detect loss");
  property p_read; regRd && regAddr == `SL_REG_STRAPSTAT |=> regRdata == {strap, 12'h000}; endproperty
  a_read: assert property (p_read) else $error("strap status mismatch");
  property p_adv; !activityPinOe_n |-> advertise == {1'b1, !strap[1], strap[1] ~^ strap[0]}; endproperty
  a_adv: assert property (p_adv) else $error("advertised abilities wrong");
  property p_dup; !activityPinOe_n |-> fullDuplexAllowed == strap[2]; endproperty
  a_dup: assert property (p_dup) else $error("duplex default wrong");
  property p_an; $fell(activityPinOe_n) |-> autonegEnable == strap[3]; endproperty
  a_an: assert property (p_an) else $error("autoneg default wrong");
endmodule : strap_and_led_status_assertions
`default_nettype wire

// ---- test_strap_and_led_status.sv ----
// Bench for the strap and indicator block: straps, registers, indicators.
// Assumes the pin model on the shared pins and shortened counts.
`include "strap_led_cfg.svh"
`default_nettype none
module test_strap_and_led_status;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] SIG = 32'h0000_0008;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic [4:0] regAddr = 5'h00;
  logic [15:0] regWdata = 16'h0000;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [15:0] regRdata, d;
  strap_led_pkg::core_status_s cs = 8'h00;
  strap_led_pkg::advert_s adv;
  logic amp = 1'b0;
  logic anEn, fdx;
  logic [3:0] pull = 4'h0;
  logic [3:0] pinIn, pinOut, pinOe_n;
  logic [7:0] stim [6] = '{8'h80, 8'h78, 8'h70, 8'h04, 8'h02, 8'h01};
  logic [3:0] want [6] = '{4'h2, 4'h8, 4'h0, 4'h1, 4'h1, 4'h1};
  int bad_count = 0;
  int samples_checked = 0;
  int ones;
  always #12.5 mclk = ~mclk;
  strap_and_led_status #(.SIGDET_CYCLES(SIG), .BLINK_CYCLES(32'h0000_0004)) i_dut (
    .mclk(mclk), .arst_n(arst_n), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .coreStatus(cs), .rxAmplitudeOk(amp),
    .activityPinIn(pinIn[0]), .activityPinOut(pinOut[0]), .activityPinOe_n(pinOe_n[0]),
    .link10PinIn(pinIn[1]), .link10PinOut(pinOut[1]), .link10PinOe_n(pinOe_n[1]),
    .link100PinIn(pinIn[2]), .link100PinOut(pinOut[2]), .link100PinOe_n(pinOe_n[2]),
    .link1000PinIn(pinIn[3]), .link1000PinOut(pinOut[3]), .link1000PinOe_n(pinOe_n[3]),
    .advertise(adv), .autonegEnable(anEn), .fullDuplexAllowed(fdx));
  strap_pin_model i_pins (.pull(pull), .drive(pinOut), .driveOe_n(pinOe_n), .level(pinIn));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : step
  task automatic set(input logic [7:0] s, input logic a);
    @(posedge mclk);
    cs <= s;
    amp <= a;
  endtask : set
  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    @(posedge mclk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= v;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [4:0] a);
    @(posedge mclk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask : rd
  task automatic reset(input logic [3:0] p);
    @(posedge mclk);
    arst_n <= 1'b0;
    pull <= p;
    repeat (6) @(posedge mclk);
    arst_n <= 1'b1;
    step(3);
  endtask : reset
  task automatic stop_test;
    if (bad_count == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : stop_test
  initial
  begin
    repeat (4000) @(posedge mclk);
    bad_count++;
    stop_test();
  end
  initial
  begin
    for (int i = 0; i < 4; i++)
    begin
      reset({i[0], ~i[1], i[1:0]});
      rd(`SL_REG_STRAPSTAT);
      chk(d, {pull, 12'h000});
      chk({13'h0000, adv}, {13'h0000, 1'b1, ~pull[1], pull[1] ~^ pull[0]});
      chk({14'h0000, anEn, fdx}, {14'h0000, pull[3:2]});
      chk({12'h000, pinOe_n}, 16'h0000);
    end
    wr(`SL_REG_CONTROL, 16'h0000);
    rd(`SL_REG_CONTROL);
    chk({d[15:1], anEn}, 16'h0000);
    wr(`SL_REG_STRAPSTAT, 16'hffff);
    wr(`SL_REG_CONTROL, 16'h1000);
    rd(`SL_REG_STRAPSTAT);
    chk(d, 16'hb000);
    rd(`SL_REG_CONTROL);
    chk(d, 16'h1000);
    rd(5'h05);
    chk(d, 16'h0000);
    for (int k = 0; k < 6; k++)
    begin
      set(stim[k], 1'b0);
      step(2);
      chk({12'h000, pinOut}, {12'h000, want[k]});
    end
    set(8'h00, 1'b1);
    step(SIG - 1);
    chk({15'h0000, pinOut[2]}, 16'h0000);
    step(1);
    chk({15'h0000, pinOut[2]}, 16'h0001);
    set(8'h00, 1'b0);
    step(1);
    chk({15'h0000, pinOut[2]}, 16'h0000);
    // Each reduced mode in turn (three-in-one, then four-in-one): merged link steady, then flashing under traffic
    for (int m = 0; m < 2; m++)
    begin
      wr(`SL_REG_LEDCFG, m ? 16'h0000 : 16'h0020);
      wr(`SL_REG_LEDALT, m ? 16'h0001 : 16'h0000);
      rd(`SL_REG_LEDCFG);
      chk(d, m ? 16'h0000 : 16'h0020);
      rd(`SL_REG_LEDALT);
      chk(d, m ? 16'h0001 : 16'h0000);
      set(8'h78, 1'b0);
      step(2);
      chk({12'h000, pinOut}, 16'h0002);
      set(8'h79, 1'b0);
      step(2);
      chk({15'h0000, pinOut[0]}, m ? 16'h0000 : 16'h0001);
      ones = 0;
      repeat (16)
      begin
        step(1);
        ones += pinOut[1];
      end
      chk(ones[15:0], 16'h0008);
    end
    stop_test();
  end
endmodule : test_strap_and_led_status
bind strap_and_led_status strap_and_led_status_assertions #(.SIGDET_CYCLES(SIGDET_CYCLES)) i_chk (
  .mclk(mclk), .arst_n(arst_n), .regAddr(regAddr), .regRd(regRd), .regRdata(regRdata),
  .coreStatus(coreStatus), .rxAmplitudeOk(rxAmplitudeOk), .activityPinIn(activityPinIn),
  .link10PinIn(link10PinIn), .link100PinIn(link100PinIn), .link1000PinIn(link1000PinIn),
  .activityPinOut(activityPinOut), .link100PinOut(link100PinOut), .link1000PinOut(link1000PinOut),
  .activityPinOe_n(activityPinOe_n), .advertise(advertise), .autonegEnable(autonegEnable),
  .fullDuplexAllowed(fullDuplexAllowed));
`default_nettype wire
